// >>> rtl/adc_ctrl_pkg.sv
// package for the converter control block: types, widths, timing counts
package adc_ctrl_pkg;
  localparam int unsigned CHAN_W = 5;
  localparam logic [4:0] CHAN_NONE = 5'h1f;
  localparam int unsigned RES_W = 10;
  localparam int unsigned LO_W = 8;
  localparam int unsigned HI_W = 2;
  localparam int unsigned DIV_W = 2;
  localparam int unsigned CNT_W = 8;
  localparam logic [7:0] SHORT_SAMPLE_CYC = 8'h03;
  localparam logic [7:0] LONG_SAMPLE_CYC = 8'h17;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [1:0] COMPARE_RESET = 2'h0;

  // configuration register fields
  typedef struct packed {
    logic low_power_select;
    logic [DIV_W-1:0] clock_divide;
    logic long_sample_select;
    logic mode_ten_bit;
    logic async_conv_clock;
  } converter_config_s;

  // status control two fields
  typedef struct packed {
    logic compare_enable;
    logic compare_greater;
    logic continuous_select;
  } status_control_two_s;

  // register write strobes, one-cycle pulses
  typedef struct packed {
    logic sc1;
    logic sc2;
    logic cfg;
    logic cvh;
    logic cvl;
  } write_strobe_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_APPROX = 2'b11,
    ST_DONE = 2'b10
  } conv_state_e;
endpackage : adc_ctrl_pkg

// >>> rtl/adc_conversion_control.sv
// control logic of a successive-approximation converter
// Behaviour
// - 10-bit compare: upper two compare bits checked against result bits 9:8.
// - 8-bit mode ignores the compare-value-high register.
// - compare-value-low checked against low eight result bits in both modes.
// - result move into result registers sets the complete flag.
// - interrupt request when complete flag sets with irq enable high.
// - 10-bit: high read, low unread blocks transfer, flag stays clear.
// - single conversion, compare false: blocking ignored, converter stops.
// - other blocked cases start another conversion.
// - status-control-one write aborts, restarts unless channel all ones.
// - writes to control two, config or compare values abort conversion.
// - reset aborts and restores result registers.
// - stop entry aborts when async conversion clock is disabled.
// - other aborts leave result registers unchanged.
// - idle until started; async clock generator enabled at start.
// - low-power select puts active converter in reduced power.
// - sampling starts on activation; long-sample select picks duration.
// - after sampling, channel disconnected and approximation runs.
// - config selects mode, clock source, divide, low power, long sample.
`timescale 1ns/1ps
module adc_conversion_control #(
  parameter int unsigned RES_BITS = adc_ctrl_pkg::RES_W
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire adc_ctrl_pkg::write_strobe_s wr_in,
  input wire logic [adc_ctrl_pkg::CHAN_W-1:0] channel_select_in,
  input wire logic complete_irq_enable_in,
  input wire adc_ctrl_pkg::status_control_two_s sc2_in,
  input wire adc_ctrl_pkg::converter_config_s converter_config_in,
  input wire logic [adc_ctrl_pkg::HI_W-1:0] compare_value_high_in,
  input wire logic [adc_ctrl_pkg::LO_W-1:0] compare_value_low_in,
  input wire logic read_result_high_in,
  input wire logic read_result_low_in,
  input wire logic stop_entry_in,
  input wire logic comparator_in,
  output logic [adc_ctrl_pkg::HI_W-1:0] result_high_out,
  output logic [adc_ctrl_pkg::LO_W-1:0] result_low_out,
  output logic conversion_complete_flag_out,
  output logic irq_out,
  output logic busy_out,
  output logic sample_connect_out,
  output logic async_clock_enable_out,
  output logic low_power_out,
  output logic [adc_ctrl_pkg::DIV_W-1:0] clock_divide_out,
  output logic [RES_BITS-1:0] dac_trial_out
);
  import adc_ctrl_pkg::*;

  // sequencer and sample timer
  conv_state_e state_ff;
  conv_state_e nxt_state;
  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] sample_len;
  logic load_sample;

  // approximation datapath
  logic [RES_BITS-1:0] sar_ff;
  logic [RES_BITS-1:0] nxt_sar;
  logic [RES_BITS-1:0] bit_ff;
  logic [RES_BITS-1:0] nxt_bit;

  // result, flag and blocking state
  logic [HI_W-1:0] result_hi_ff;
  logic [LO_W-1:0] result_lo_ff;
  logic conversion_complete_flag_ff;
  logic irq_ff;
  logic block_ff;

  // write decode, compare and transfer decisions
  logic restart;
  logic abort_mode;
  logic abort_stop;
  logic abort_any;
  logic cmp_ge;
  logic cmp_lt;
  logic cmp_true;
  logic blocked;
  logic transfer;
  logic flag_set;
  logic irq_set;
  logic rerun;
  logic [RES_W-1:0] conv_val;
  logic [RES_W-1:0] cmp_val;

  // mode-change writes: the running result would be stale
  assign abort_mode = wr_in.sc2 | wr_in.cfg | wr_in.cvh | wr_in.cvl;
  // stop only kills the run when the conversion clock is not the async one
  assign abort_stop = stop_entry_in & ~converter_config_in.async_conv_clock;
  // any write that changes the operating mode kills the conversion
  assign abort_any = wr_in.sc1 | abort_mode | abort_stop;
  assign restart = wr_in.sc1 & (channel_select_in != CHAN_NONE);

  // 8-bit results sit in the low byte
  always_comb begin
    conv_val = RES_W'(sar_ff);
    if (!converter_config_in.mode_ten_bit) begin
      conv_val = {{HI_W{1'b0}}, sar_ff[RES_BITS-1 -: LO_W]};
    end
  end

  // compare value: high bits only count in 10-bit mode
  always_comb begin
    cmp_val = {compare_value_high_in, compare_value_low_in};
    if (!converter_config_in.mode_ten_bit) begin
      cmp_val = {{HI_W{1'b0}}, compare_value_low_in};
    end
  end

  // both senses worked out; the greater bit only picks between them
  assign cmp_ge = (conv_val >= cmp_val);
  assign cmp_lt = (conv_val < cmp_val);

  // compare off means every result counts as a match
  always_comb begin
    cmp_true = 1'b1;
    if (sc2_in.compare_enable) begin
      cmp_true = sc2_in.compare_greater ? cmp_ge : cmp_lt;
    end
  end

  // result move decision at end of approximation
  assign blocked = block_ff & converter_config_in.mode_ten_bit;
  assign transfer = (state_ff == ST_DONE) & cmp_true & ~blocked;
  // a transfer in the same cycle as an abort is dropped with the conversion
  assign flag_set = transfer & ~abort_any;
  assign irq_set = flag_set & complete_irq_enable_in;

  // end of approximation: decide whether the converter goes round again
  always_comb begin
    rerun = 1'b0;
    if (state_ff == ST_DONE) begin
      if (blocked) begin
        // a blocked result reruns, except single compare-false which stops
        rerun = sc2_in.continuous_select | ~sc2_in.compare_enable | cmp_true;
      end else begin
        // continuous mode goes again after every result, matched or not
        rerun = sc2_in.continuous_select;
      end
    end
  end

  // sequencer: idle, sample, approximate, done
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        // leaving idle only happens through the write path below
        nxt_state = ST_IDLE;
      end
      ST_SAMPLE: begin
        // hold the channel until the timer runs out
        if (count_ff == '0) begin
          nxt_state = ST_APPROX;
        end
      end
      ST_APPROX: begin
        // last bit weighed in this cycle
        if (bit_ff[0]) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        nxt_state = rerun ? ST_SAMPLE : ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (abort_any) begin
      nxt_state = restart ? ST_SAMPLE : ST_IDLE;
    end
  end

  // state register, reset aborts any run
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // sample length picked at each load, short or long
  assign sample_len = converter_config_in.long_sample_select ? CNT_W'(LONG_SAMPLE_CYC)
                                                             : CNT_W'(SHORT_SAMPLE_CYC);
  // a restart during sampling must reload, not carry on with the old count
  assign load_sample = (nxt_state == ST_SAMPLE) & ((state_ff != ST_SAMPLE) | abort_any);

  // sample timer loaded on each entry to sampling
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      count_ff <= '0;
    end else if (load_sample) begin
      count_ff <= sample_len;
    end else if (state_ff == ST_SAMPLE && count_ff != '0) begin
      count_ff <= count_ff - CNT_W'(1);
    end
  end

  // next trial; the analog side gets it in the same cycle as the register,
  // so the comparator always answers for the trial being held
  always_comb begin
    nxt_sar = sar_ff;
    nxt_bit = bit_ff;
    if (state_ff == ST_SAMPLE) begin
      nxt_sar = {1'b1, {(RES_BITS-1){1'b0}}};
      nxt_bit = {1'b1, {(RES_BITS-1){1'b0}}};
    end else if (state_ff == ST_APPROX) begin
      // comparator high means input below trial, so drop the bit
      nxt_sar = (comparator_in ? (sar_ff & ~bit_ff) : sar_ff) | (bit_ff >> 1);
      nxt_bit = bit_ff >> 1;
    end
  end

  // successive approximation: one bit per cycle, msb first
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sar_ff <= '0;
      bit_ff <= '0;
    end else begin
      sar_ff <= nxt_sar;
      bit_ff <= nxt_bit;
    end
  end

  // result high bits only change on a good transfer or reset
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      result_hi_ff <= RESULT_RESET[RES_W-1 -: HI_W];
    end else if (flag_set) begin
      result_hi_ff <= conv_val[RES_W-1 -: HI_W];
    end
  end

  // low byte kept apart so each half is its own register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      result_lo_ff <= RESULT_RESET[LO_W-1:0];
    end else if (flag_set) begin
      result_lo_ff <= conv_val[LO_W-1:0];
    end
  end

  // high read arms blocking until the low byte is read
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      block_ff <= 1'b0;
    end else if (read_result_low_in) begin
      block_ff <= 1'b0;
    end else if (read_result_high_in) begin
      block_ff <= 1'b1;
    end
  end

  // complete flag: set wins over the clear from a low read; an sc1 write masks the set and clears
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      conversion_complete_flag_ff <= 1'b0;
    end else if (flag_set) begin
      conversion_complete_flag_ff <= 1'b1;
    end else if (wr_in.sc1 || read_result_low_in) begin
      conversion_complete_flag_ff <= 1'b0;
    end
  end

  // interrupt request follows flag, set only with enable high and cleared whenever enable is low
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_ff <= 1'b0;
    end else if (irq_set) begin
      irq_ff <= 1'b1;
    end else if (wr_in.sc1 || read_result_low_in || !complete_irq_enable_in) begin
      irq_ff <= 1'b0;
    end
  end

  // busy while anything but idle is coming; registered so the pin is clean
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= (nxt_state != ST_IDLE);
    end
  end

  // input switch closed only while sampling
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sample_connect_out <= 1'b0;
    end else begin
      sample_connect_out <= (nxt_state == ST_SAMPLE);
    end
  end

  // async clock generator runs only for an active conversion
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      async_clock_enable_out <= 1'b0;
    end else begin
      async_clock_enable_out <= (nxt_state != ST_IDLE)
                                & converter_config_in.async_conv_clock;
    end
  end

  // reduced power only matters while the converter is active
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      low_power_out <= 1'b0;
    end else begin
      low_power_out <= (nxt_state != ST_IDLE)
                       & converter_config_in.low_power_select;
    end
  end

  // divide ratio passed on; the clock itself is made outside
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      clock_divide_out <= '0;
    end else begin
      clock_divide_out <= converter_config_in.clock_divide;
    end
  end

  // trial value to the analog side, in step with the sar register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dac_trial_out <= '0;
    end else begin
      dac_trial_out <= nxt_sar;
    end
  end

  // result bytes and status straight off their registers
  assign result_high_out = result_hi_ff;
  assign result_low_out = result_lo_ff;
  assign conversion_complete_flag_out = conversion_complete_flag_ff;
  assign irq_out = irq_ff;
endmodule : adc_conversion_control

// >>> tb/adc_ctrl_monitor.sv
// port checker for the converter control block
`timescale 1ns/1ps
module adc_ctrl_monitor (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire adc_ctrl_pkg::write_strobe_s wr_in,
  input wire logic [adc_ctrl_pkg::CHAN_W-1:0] channel_select_in,
  input wire logic complete_irq_enable_in,
  input wire adc_ctrl_pkg::converter_config_s converter_config_in,
  input wire logic stop_entry_in,
  input wire logic [adc_ctrl_pkg::HI_W-1:0] result_high_out,
  input wire logic [adc_ctrl_pkg::LO_W-1:0] result_low_out,
  input wire logic conversion_complete_flag_out,
  input wire logic irq_out,
  input wire logic busy_out,
  input wire logic sample_connect_out
);
  import adc_ctrl_pkg::*;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // clean start: status one alone, real channel, no stop request
  sequence s_start;
    wr_in.sc1 && channel_select_in != CHAN_NONE && wr_in[3:0] == 4'h0 && !stop_entry_in;
  endsequence
  // short window, then the input is let go
  sequence s_short;
    sample_connect_out [*4] ##1 !sample_connect_out;
  endsequence
  a_start_busy: assert property (s_start |=> busy_out && sample_connect_out)
    else $error("no start");
  a_short_sample: assert property (s_start ##0 !converter_config_in.long_sample_select |=> s_short)
    else $error("short sample length");
  a_long_sample: assert property (s_start ##0 converter_config_in.long_sample_select |=> sample_connect_out [*8])
    else $error("long sample cut");
  a_none_idle: assert property (wr_in.sc1 && channel_select_in == CHAN_NONE |=> !busy_out)
    else $error("started on no channel");
  a_abort_write: assert property (wr_in[3:0] != 4'h0 && !wr_in.sc1 |=> !busy_out)
    else $error("write did not abort");
  a_stop_abort: assert property (stop_entry_in && !converter_config_in.async_conv_clock && !wr_in.sc1 |=> !busy_out)
    else $error("stop did not abort");
  a_idle_stays: assert property (!busy_out && !wr_in.sc1 |=> !busy_out)
    else $error("left idle unasked");
  a_result_flag: assert property (!$stable({result_high_out, result_low_out}) |-> conversion_complete_flag_out)
    else $error("result moved without flag");
  a_irq_on_set: assert property ($rose(conversion_complete_flag_out) && complete_irq_enable_in |-> irq_out)
    else $error("no irq on flag");
endmodule : adc_ctrl_monitor

bind adc_conversion_control adc_ctrl_monitor u_mon (.*);

// >>> tb/tb_adc_conversion_control.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_adc_conversion_control;
  import adc_ctrl_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  write_strobe_s wr_in = '0;
  logic [4:0] channel_select_in = 5'h01;
  logic complete_irq_enable_in = 1'b1;
  status_control_two_s sc2_in = '0;
  converter_config_s converter_config_in = 6'h3f;
  logic [1:0] compare_value_high_in = 2'h0;
  logic [7:0] compare_value_low_in = 8'h00;
  logic read_result_high_in = 1'b0;
  logic read_result_low_in = 1'b0;
  logic stop_entry_in = 1'b0;
  logic comparator_in;
  logic [1:0] result_high_out;
  logic [7:0] result_low_out;
  logic conversion_complete_flag_out, irq_out, busy_out, sample_connect_out;
  logic async_clock_enable_out, low_power_out;
  logic [1:0] clock_divide_out;
  logic [9:0] dac_trial_out, res;
  logic [9:0] analog = 10'h155;
  logic hit;
  int n_mismatch = 0;
  int num_checks = 0;
  // input held as a level; comparator reports it below the trial
  assign comparator_in = analog < dac_trial_out;
  assign res = {result_high_out, result_low_out};
  adc_conversion_control dut (.*);
  initial forever #2 clk_in = ~clk_in;
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : step
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : chk
  // one-cycle strobe, taken at the next edge
  task automatic pulse(input write_strobe_s w);
    wr_in = w;
    step(1);
    wr_in = '0;
  endtask : pulse
  task automatic go(input logic [4:0] ch);
    channel_select_in = ch;
    pulse(5'h10);
  endtask : go
  task automatic rd(input logic hi);
    read_result_high_in = hi;
    read_result_low_in = !hi;
    step(1);
    read_result_high_in = 1'b0;
    read_result_low_in = 1'b0;
  endtask : rd
  // bounded wait for the complete flag
  task automatic run(input int lim);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      step(1);
      hit = conversion_complete_flag_out === 1'b1;
    end
  endtask : run
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  // long sample, async clock, low power, ten bits
  task automatic t_basic;
    go(5'h01);
    chk(busy_out & sample_connect_out & async_clock_enable_out, "start");
    chk(low_power_out === 1'b1 && clock_divide_out === 2'h3, "cfg");
    run(60);
    chk(hit && res === 10'h155 && irq_out === 1'b1, "result");
    chk(sample_connect_out === 1'b0, "disconnect");
  endtask : t_basic
  // every abort source except reset, mid-run; the last good result stays
  task automatic t_abort;
    write_strobe_s ws[5] = '{5'h08, 5'h04, 5'h02, 5'h01, 5'h00};
    converter_config_in = 6'h02;
    analog = 10'h2aa;
    foreach (ws[i]) begin
      go(5'h02);
      step(8);
      if (i < 4) begin
        pulse(ws[i]);
      end else begin
        stop_entry_in = 1'b1;
        step(1);
        stop_entry_in = 1'b0;
      end
      chk(busy_out === 1'b0 && res === 10'h155, "abort");
    end
    go(5'h02);
    step(8);
    go(5'h03);
    chk(busy_out === 1'b1 && sample_connect_out === 1'b1, "restart");
    step(5);
    go(CHAN_NONE);
    step(20);
    chk(busy_out === 1'b0 && res === 10'h155, "idle");
  endtask : t_abort
  // high byte read, then a new result arrives before the low read
  task automatic t_block;
    analog = 10'h0f0;
    go(5'h01);
    run(40);
    chk(hit && res === 10'h0f0, "first");
    rd(1'b1);
    analog = 10'h30f;
    go(5'h01);
    run(40);
    chk(!hit && busy_out === 1'b1 && res === 10'h0f0, "blocked");
    rd(1'b0);
    run(40);
    chk(hit && res === 10'h30f, "released");
  endtask : t_block
  // entries {ten_bit, greater, high, low, expect flag}
  task automatic t_cmp;
    logic [12:0] tc[5] = '{13'h1aab, 13'h1c00, 13'h1aac, 13'h12ad, 13'h0e01};
    analog = 10'h155;
    foreach (tc[i]) begin
      converter_config_in = {4'h0, tc[i][12], 1'b0};
      sc2_in = {1'b1, tc[i][11], 1'b0};
      {compare_value_high_in, compare_value_low_in} = tc[i][10:1];
      rd(1'b0);
      go(5'h01);
      run(40);
      chk(hit === tc[i][0] && busy_out === 1'b0, "compare");
    end
  endtask : t_cmp
  // reset mid-conversion clears the results
  task automatic t_reset;
    go(5'h01);
    step(8);
    rst_n_in = 1'b0;
    step(2);
    chk(busy_out === 1'b0 && res === RESULT_RESET, "reset");
    rst_n_in = 1'b1;
  endtask : t_reset
  initial begin
    step(10);
    rst_n_in = 1'b1;
    t_basic();
    t_abort();
    t_block();
    t_cmp();
    t_reset();
    close_out();
  end
  // watchdog, several times the expected run
  initial begin
    #20000;
    n_mismatch++;
    close_out();
  end
endmodule : tb_adc_conversion_control
